// [logic/odp_ports.sv]
`timescale 1ns/1ps
module odp_ports
	import odp_pkg::*;
#(
	parameter int DW = D_WIDTH
)(
	input  wire logic           ref_clk,
	input  wire logic           rst_b,
	input  wire odp_op_t        port_op,
	input  wire logic           test_port_bit_skip_op,
	input  wire logic           skip_on_irq_pin_op,
	input  wire logic [3:0]     bit_ptr,
	input  wire logic [DW-1:0]  d_pin_in,
	output logic      [DW-1:0]  d_pad_oe,
	output logic      [DW-1:0]  d_strong,
	output logic                skip_req,
	input  wire logic [3:0]     p0_wr_data,
	input  wire logic           p0_wr_en,
	input  wire logic [3:0]     p1_wr_data,
	input  wire logic           p1_wr_en,
	input  wire logic [7:0]     pullup_ctrl_bits,
	input  wire logic           pullup_wr_en,
	input  wire logic [7:0]     key_ctrl_bits,
	input  wire logic           key_wr_en,
	input  wire logic [3:0]     p0_pin_in,
	input  wire logic [3:0]     p1_pin_in,
	output logic      [3:0]     p0_pad_oe,
	output logic      [3:0]     p1_pad_oe,
	output logic      [3:0]     p0_pad_pu,
	output logic      [3:0]     p1_pad_pu,
	output logic      [3:0]     p0_rd_data,
	output logic      [3:0]     p1_rd_data,
	input  wire logic [3:0]     p2_pin_in,
	input  wire logic [3:0]     p3_pin_in,
	input  wire logic [3:0]     p4_pin_in,
	input  wire logic           p3_seg_sel,
	input  wire logic           p4_seg_sel,
	output logic      [3:0]     p2_rd_data,
	output logic      [3:0]     p3_rd_data,
	output logic      [3:0]     p4_rd_data,
	input  wire logic           irq0_wake_en,
	output logic                ext_irq_zero_in,
	output logic                zero_cross_in,
	output logic                wake_req,
	input  wire logic           tmr1_sel,
	input  wire logic           tmr1_uf,
	input  wire logic           tmr2_sel,
	input  wire logic           tmr2_uf,
	output logic                timer1_underflow_out,
	output logic                timer2_out_event_in,
	input  wire logic [1:0]     d10_sel,
	input  wire logic           sout,
	input  wire logic           realtime_out_zero,
	input  wire logic           realtime_out_one,
	input  wire logic           pwm_out,
	input  wire logic           sck_sel,
	input  wire logic           sck_out_en,
	input  wire logic           sck_out,
	output logic                sck_in
);
	// ------------------------------------------------
	// port d latches
	// ------------------------------------------------
	logic [DW-1:0] d_latch;
	logic [DW-1:0] d_drive_low;
	logic          ptr_ok;

	assign ptr_ok = (bit_ptr < 4'(DW));

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			d_latch <= D_LATCH_RST;
		end else begin
			case (port_op)
				ODP_OP_SET: if (ptr_ok) d_latch[bit_ptr] <= 1'b1;
				ODP_OP_CLR: if (ptr_ok) d_latch[bit_ptr] <= 1'b0;
				ODP_OP_ALL: d_latch <= D_LATCH_RST;
				default: d_latch <= d_latch;
			endcase
		end
	end

	// ------------------------------------------------
	// pad drive with alternate functions
	// ------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < DW; gi++) begin : g_drv
			always_comb begin
				d_drive_low[gi] = ~d_latch[gi];
				if (gi == BIT_TMR1 && tmr1_sel) begin
					d_drive_low[gi] = ~tmr1_uf;
				end else if (gi == BIT_TMR2 && tmr2_sel) begin
					d_drive_low[gi] = ~tmr2_uf;
				// serial clock out or released for input
				end else if (gi == BIT_SCK && sck_sel) begin
					d_drive_low[gi] = sck_out_en & ~sck_out;
				end else if (gi == BIT_SOUT && d10_sel != D10_LATCH) begin
					case (d10_sel)
						D10_SOUT: d_drive_low[gi] = ~sout;
						D10_REALTIME_OUT_ONE: d_drive_low[gi] = ~realtime_out_one;
						default:  d_drive_low[gi] = ~pwm_out;
					endcase
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			d_pad_oe <= '0;
			d_strong <= '0;
		end else begin
			d_pad_oe <= d_drive_low;
			d_strong <= d_drive_low & D_STRONG_MASK[DW-1:0];
		end
	end

	// ------------------------------------------------
	// skip tests, interrupt-zero pin and other sampled inputs
	// ------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			skip_req <= 1'b0;
		end else if (test_port_bit_skip_op) begin
			skip_req <= ptr_ok && !d_pin_in[bit_ptr];
		end else if (skip_on_irq_pin_op) begin
			skip_req <= !d_pin_in[BIT_IRQ0];
		end else begin
			skip_req <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			ext_irq_zero_in     <= 1'b0;
			zero_cross_in       <= 1'b0;
			timer2_out_event_in <= 1'b0;
			sck_in              <= 1'b0;
			timer1_underflow_out <= 1'b0;
		end else begin
			ext_irq_zero_in      <= d_pin_in[BIT_IRQ0];
			zero_cross_in        <= d_pin_in[BIT_IRQ0];
			timer2_out_event_in  <= d_pin_in[BIT_TMR2];
			sck_in               <= d_pin_in[BIT_SCK];
			timer1_underflow_out <= tmr1_sel & tmr1_uf;
		end
	end

	// ------------------------------------------------
	// bidirectional nibble ports
	// ------------------------------------------------
	odp_nib_if nb0 ();
	odp_nib_if nb1 ();
	assign nb0.wr_data  = p0_wr_data;
	assign nb0.wr_en    = p0_wr_en;
	assign nb0.pu_data  = pullup_ctrl_bits[3:0];
	assign nb0.pu_en    = pullup_wr_en;
	assign nb0.key_data = key_ctrl_bits[3:0];
	assign nb0.key_en   = key_wr_en;
	assign nb0.pin_in   = p0_pin_in;
	assign nb1.wr_data  = p1_wr_data;
	assign nb1.wr_en    = p1_wr_en;
	assign nb1.pu_data  = pullup_ctrl_bits[7:4];
	assign nb1.pu_en    = pullup_wr_en;
	assign nb1.key_data = key_ctrl_bits[7:4];
	assign nb1.key_en   = key_wr_en;
	assign nb1.pin_in   = p1_pin_in;

	odp_nib_port u_p0 (.ref_clk(ref_clk), .rst_b(rst_b), .nb(nb0.port));
	odp_nib_port u_p1 (.ref_clk(ref_clk), .rst_b(rst_b), .nb(nb1.port));

	assign p0_pad_oe  = nb0.pad_oe;
	assign p1_pad_oe  = nb1.pad_oe;
	assign p0_pad_pu  = nb0.pad_pu;
	assign p1_pad_pu  = nb1.pad_pu;
	assign p0_rd_data = nb0.rd_data;
	assign p1_rd_data = nb1.rd_data;

	// ------------------------------------------------
	// input-only ports and wakeup
	// ------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			p2_rd_data <= 4'h0;
			p3_rd_data <= 4'h0;
			p4_rd_data <= 4'h0;
			wake_req   <= 1'b0;
		end else begin
			// input only; segment use reads zero
			p2_rd_data <= p2_pin_in;
			p3_rd_data <= p3_seg_sel ? 4'h0 : p3_pin_in;
			p4_rd_data <= p4_seg_sel ? 4'h0 : p4_pin_in;
			wake_req   <= nb0.wake | nb1.wake | (irq0_wake_en & ~d_pin_in[BIT_IRQ0]);
		end
	end
endmodule

// [shared/odp_pkg.sv]
package odp_pkg;
	localparam int D_WIDTH   = 11;
	localparam int NIB_WIDTH = 4;
	localparam int PTR_WIDTH = 4;
	// port d bit positions with alternate functions
	localparam int BIT_TMR1   = 6;
	localparam int BIT_TMR2   = 7;
	localparam int BIT_IRQ0   = 8;
	localparam int BIT_SCK    = 9;
	localparam int BIT_SOUT   = 10;
	// latches release every pin after reset
	localparam logic [10:0] D_LATCH_RST  = 11'h7FF;
	localparam logic [3:0]  NIB_LATCH_RST = 4'hF;
	localparam logic [3:0]  PU_RST        = 4'h0;
	// pins with the strong sink driver (all but bit nine)
	localparam logic [10:0] D_STRONG_MASK = 11'h5FF;
	// d10 source select codes
	localparam logic [1:0]  D10_LATCH = 2'h0;
	localparam logic [1:0]  D10_SOUT  = 2'h1;
	localparam logic [1:0]  D10_REALTIME_OUT_ONE  = 2'h2;
	localparam logic [1:0]  D10_PWM   = 2'h3;

	typedef enum logic [3:0] {
		ODP_OP_NONE  = 4'h1,
		ODP_OP_SET   = 4'h2,
		ODP_OP_CLR   = 4'h4,
		ODP_OP_ALL   = 4'h8
	} odp_op_t;
endpackage

// [shared/odp_nib_if.sv]
`timescale 1ns/1ps
interface odp_nib_if;
	logic [3:0] wr_data;
	logic       wr_en;
	logic [3:0] pu_data;
	logic       pu_en;
	logic [3:0] key_data;
	logic       key_en;
	logic [3:0] pin_in;
	logic [3:0] pad_oe;
	logic [3:0] pad_pu;
	logic [3:0] rd_data;
	logic       wake;
	modport port (input wr_data, wr_en, pu_data, pu_en, key_data, key_en, pin_in,
		output pad_oe, pad_pu, rd_data, wake);
	modport ctrl (output wr_data, wr_en, pu_data, pu_en, key_data, key_en, pin_in,
		input pad_oe, pad_pu, rd_data, wake);
endinterface

// [logic/odp_nib_port.sv]
`timescale 1ns/1ps
module odp_nib_port
	import odp_pkg::*;
(
	input  wire logic ref_clk,
	input  wire logic rst_b,
	odp_nib_if.port   nb
);
	logic [3:0] latch;
	logic [3:0] pu;
	logic [3:0] key;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			latch <= NIB_LATCH_RST;
		end else if (nb.wr_en) begin
			latch <= nb.wr_data;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pu <= PU_RST;
			key <= PU_RST;
		end else begin
			if (nb.pu_en) begin
				pu <= nb.pu_data;
			end
			if (nb.key_en) begin
				key <= nb.key_data;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			nb.pad_oe  <= 4'h0;
			nb.pad_pu  <= 4'h0;
			nb.rd_data <= 4'h0;
			nb.wake    <= 1'b0;
		end else begin
			nb.pad_oe  <= ~latch;
			// pull-up is pointless while the pin sinks, so drop it then
			nb.pad_pu  <= pu & latch;
			nb.rd_data <= nb.pin_in & latch;
			nb.wake    <= |(key & latch & ~nb.pin_in);
		end
	end
endmodule

// [bench/odp_ports_monitor.sv]
`timescale 1ns/1ps
// ----------------------------------------
// port pin checks
// ----------------------------------------
module odp_ports_monitor
	import odp_pkg::*;
(
	input wire logic        ref_clk,
	input wire logic        rst_b,
	input wire odp_op_t     port_op,
	input wire logic        test_port_bit_skip_op,
	input wire logic        skip_on_irq_pin_op,
	input wire logic [3:0]  bit_ptr,
	input wire logic [10:0] d_pin_in,
	input wire logic [10:0] d_pad_oe,
	input wire logic [10:0] d_strong,
	input wire logic        skip_req,
	input wire logic        p3_seg_sel,
	input wire logic [3:0]  p3_rd_data,
	input wire logic        irq0_wake_en,
	input wire logic        wake_req,
	input wire logic        tmr1_sel,
	input wire logic        tmr1_uf,
	input wire logic        timer1_underflow_out
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence s_clr;
		port_op == ODP_OP_CLR && bit_ptr < 4'hB;
	endsequence
	property p_clr;
		s_clr |-> ##2 d_pad_oe[$past(bit_ptr, 2)];
	endproperty
	property p_all;
		port_op == ODP_OP_ALL |-> ##2 d_pad_oe == 11'h000;
	endproperty
	property p_strong;
		d_strong == (d_pad_oe & D_STRONG_MASK);
	endproperty
	property p_skip;
		test_port_bit_skip_op && bit_ptr < 4'hB |=> skip_req == !$past(d_pin_in[bit_ptr]);
	endproperty
	property p_irq;
		skip_on_irq_pin_op && !test_port_bit_skip_op |=> skip_req == !$past(d_pin_in[BIT_IRQ0]);
	endproperty
	property p_tmr1;
		1'b1 |=> timer1_underflow_out == $past(tmr1_sel && tmr1_uf);
	endproperty
	property p_seg;
		p3_seg_sel |=> p3_rd_data == 4'h0;
	endproperty
	property p_wake;
		irq0_wake_en && !d_pin_in[BIT_IRQ0] |=> wake_req;
	endproperty
	a_clr: assert property (p_clr) else $error("cleared pin not sinking");
	a_all: assert property (p_all) else $error("pins not all released");
	a_strong: assert property (p_strong) else $error("strong sink wrong");
	a_skip: assert property (p_skip) else $error("bit test wrong");
	a_irq: assert property (p_irq) else $error("irq pin test wrong");
	a_tmr1: assert property (p_tmr1) else $error("timer out wrong");
	a_seg: assert property (p_seg) else $error("segment pins read");
	a_wake: assert property (p_wake) else $error("no irq wakeup");
endmodule

// [bench/odp_pad_model.sv]
`timescale 1ns/1ps
module odp_pad_model #(
	parameter int W = 4
)(
	input  wire logic         ref_clk,
	input  wire logic [W-1:0] oe,
	input  wire logic [W-1:0] pu,
	input  wire logic [W-1:0] ext_low,
	output logic      [W-1:0] pin
);
	logic flip = 1'b0;
	// a released pad without pull-up wanders, never trust its last level
	always @(posedge ref_clk) flip <= ~flip;
	always_comb for (int i = 0; i < W; i++) pin[i] = (oe[i] | ext_low[i]) ? 1'b0 : (pu[i] | flip);
endmodule

// [bench/odp_ports_tb.sv]
`timescale 1ns/1ps
module odp_ports_tb;
	import odp_pkg::*;
	logic        ref_clk, rst_b, test_port_bit_skip_op, skip_on_irq_pin_op, p0_wr_en, p1_wr_en, pullup_wr_en;
	logic        key_wr_en, p3_seg_sel, irq0_wake_en, tmr1_sel, sck_sel, src, skip_req, ext_irq_zero_in;
	logic        zero_cross_in, wake_req, timer1_underflow_out, timer2_out_event_in, sck_in;
	odp_op_t     port_op;
	logic [1:0]  d10_sel;
	logic [3:0]  bit_ptr, p0_wr_data, p1_wr_data, p0_pin_in, p1_pin_in, pn, ext_n, p0_pad_oe, p1_pad_oe;
	logic [3:0]  p0_pad_pu, p1_pad_pu, p0_rd_data, p1_rd_data, p2_rd_data, p3_rd_data, p4_rd_data;
	logic [7:0]  pullup_ctrl_bits, key_ctrl_bits;
	logic [10:0] d_pin_in, d_pad_oe, d_strong, ext_d;
	logic [31:0] rnd;
	int          num_errors, check_count, b, lat[11];
	odp_ports u_odp_ports (.ref_clk, .rst_b, .port_op, .test_port_bit_skip_op, .skip_on_irq_pin_op, .bit_ptr,
		.d_pin_in, .d_pad_oe, .d_strong, .skip_req, .p0_wr_data, .p0_wr_en, .p1_wr_data, .p1_wr_en,
		.pullup_ctrl_bits, .pullup_wr_en, .key_ctrl_bits, .key_wr_en, .p0_pin_in, .p1_pin_in, .p0_pad_oe,
		.p1_pad_oe, .p0_pad_pu, .p1_pad_pu, .p0_rd_data, .p1_rd_data, .p2_pin_in(pn), .p3_pin_in(pn),
		.p4_pin_in(pn), .p3_seg_sel, .p4_seg_sel(p3_seg_sel), .p2_rd_data, .p3_rd_data, .p4_rd_data,
		.irq0_wake_en, .ext_irq_zero_in, .zero_cross_in, .wake_req, .tmr1_sel, .tmr1_uf(src),
		.tmr2_sel(tmr1_sel), .tmr2_uf(src), .timer1_underflow_out, .timer2_out_event_in, .d10_sel,
		.sout(src), .realtime_out_zero(src), .realtime_out_one(src), .pwm_out(src), .sck_sel,
		.sck_out_en(sck_sel), .sck_out(src), .sck_in);
	odp_pad_model #(.W(11)) u_pad_d (.ref_clk, .oe(d_pad_oe), .pu(11'h7FF), .ext_low(ext_d), .pin(d_pin_in));
	odp_pad_model u_pad_0 (.ref_clk, .oe(p0_pad_oe), .pu(p0_pad_pu), .ext_low(ext_n), .pin(p0_pin_in));
	odp_pad_model u_pad_1 (.ref_clk, .oe(p1_pad_oe), .pu(p1_pad_pu), .ext_low(ext_n), .pin(p1_pin_in));
	always #12.5 ref_clk = ~ref_clk;
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [10:0] exp_oe();
		for (int i = 0; i < 11; i++) exp_oe[i] = lat[i] == 0;
	endfunction
	task automatic chk(logic [15:0] seen, logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic op(odp_op_t o, int p);
		port_op = o;
		bit_ptr = 4'(p);
		if (o == ODP_OP_ALL) foreach (lat[i]) lat[i] = 1;
		else if (p < 11) lat[p] = o == ODP_OP_SET;
		cyc(1);
		port_op = ODP_OP_NONE;
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (3000) @(posedge ref_clk);
		num_errors++;
		end_of_test();
	end
	initial begin
		{ref_clk, rst_b, test_port_bit_skip_op, skip_on_irq_pin_op, p0_wr_en, p1_wr_en, pullup_wr_en} = '0;
		{key_wr_en, p3_seg_sel, irq0_wake_en, tmr1_sel, sck_sel, src, d10_sel, bit_ptr, p0_wr_data} = '0;
		{p1_wr_data, pn, ext_n, pullup_ctrl_bits, key_ctrl_bits, ext_d} = '0;
		port_op = ODP_OP_NONE;
		rnd = 32'hAFDD;
		foreach (lat[i]) lat[i] = 1;
		cyc(3);
		rst_b = 1'b1;
		cyc(1);
		chk(d_pad_oe, 0);
		chk({p1_pad_oe, p0_pad_oe}, 0);
		chk({ext_irq_zero_in, zero_cross_in, timer2_out_event_in, sck_in}, 4'hF);
		$display("reset done");
		repeat (24) begin
			rnd = lfsr(rnd);
			b = rnd[7:0] % 11;
			ext_d = rnd[18:8];
			op(rnd[20] ? ODP_OP_SET : ODP_OP_CLR, b);
			// the new latch needs one more edge to reach the pad
			cyc(1);
			test_port_bit_skip_op = 1'b1;
			cyc(1);
			test_port_bit_skip_op = 1'b0;
			chk(d_pad_oe, exp_oe());
			chk(skip_req, lat[b] == 0 || ext_d[b]);
		end
		op(ODP_OP_CLR, 13);
		test_port_bit_skip_op = 1'b1;
		cyc(1);
		test_port_bit_skip_op = 1'b0;
		chk(skip_req, 0);
		chk(d_pad_oe, exp_oe());
		op(ODP_OP_ALL, 0);
		cyc(1);
		chk(d_pad_oe, 0);
		ext_d = 11'h100;
		{skip_on_irq_pin_op, irq0_wake_en} = 2'h3;
		cyc(1);
		{skip_on_irq_pin_op, irq0_wake_en, ext_d} = '0;
		chk(skip_req, 1);
		chk(wake_req, 1);
		chk({ext_irq_zero_in, zero_cross_in}, 0);
		$display("port d done");
		rnd = lfsr(rnd);
		{p1_wr_data, p0_wr_data} = rnd[7:0];
		ext_n = rnd[11:8];
		{pullup_ctrl_bits, key_ctrl_bits} = 16'hFFFF;
		{p0_wr_en, p1_wr_en, pullup_wr_en, key_wr_en} = 4'hF;
		cyc(1);
		{p0_wr_en, p1_wr_en, pullup_wr_en, key_wr_en} = 4'h0;
		cyc(3);
		chk({p1_pad_oe, p0_pad_oe}, {8'h00, ~rnd[7:0]});
		chk({p1_pad_pu, p0_pad_pu}, rnd[7:0]);
		chk({p1_rd_data, p0_rd_data}, rnd[7:0] & ~{ext_n, ext_n});
		chk(wake_req, |(rnd[7:0] & {ext_n, ext_n}));
		pullup_ctrl_bits = ~{ext_n, ext_n};
		pullup_wr_en = 1'b1;
		cyc(1);
		pullup_wr_en = 1'b0;
		cyc(2);
		chk({p1_pad_pu, p0_pad_pu}, rnd[7:0] & ~{ext_n, ext_n});
		rst_b = 1'b0;
		cyc(1);
		rst_b = 1'b1;
		cyc(2);
		chk({p1_pad_oe, p0_pad_oe}, 0);
		for (int s = 0; s < 2; s++) begin
			{p3_seg_sel, pn} = {s[0], rnd[15:12]};
			cyc(2);
			chk({p4_rd_data, p3_rd_data, p2_rd_data}, {s ? 8'h00 : {pn, pn}, pn});
		end
		$display("nibble ports done");
		{tmr1_sel, sck_sel} = 2'h3;
		for (int s = 1; s < 4; s++) begin
			{d10_sel, src} = {2'(s), 1'b0};
			cyc(2);
			chk(d_pad_oe, 11'h6C0);
			chk({timer2_out_event_in, sck_in}, 0);
			chk(timer1_underflow_out, 0);
			src = 1'b1;
			cyc(2);
			chk(d_pad_oe, 0);
			chk({timer2_out_event_in, sck_in}, 2'h3);
			chk(timer1_underflow_out, 1);
		end
		$display("alternate pins done");
		end_of_test();
	end
endmodule
bind odp_ports odp_ports_monitor u_odp_ports_monitor (.ref_clk, .rst_b, .port_op, .test_port_bit_skip_op,
	.skip_on_irq_pin_op, .bit_ptr, .d_pin_in, .d_pad_oe, .d_strong, .skip_req, .p3_seg_sel, .p3_rd_data,
	.irq0_wake_en, .wake_req, .tmr1_sel, .tmr1_uf, .timer1_underflow_out);
